// ==== core/nand_seq_pkg.sv ====
// Purpose: Shared constants for the NAND device-side command sequencer.
// Assumes: 100 MHz mclk, x8 multiplexed command/address/data bus.
// Notes:   Busy times are typical figures; counts are derived below.
//
// Summary of operation
// - With volatile_block_lock enabled at power-up, all blocks locked until unlock range set.
// - Chip select may rise during data load or read; transfer state is kept.
// - Blocks 0 to 7 are always good when shipped.
// - As delivered, every byte in valid blocks reads as FFh.
package nand_seq_pkg;
	localparam int CLK_MHZ = 100;

	// Command codes
	localparam logic [7:0] CMD_READ      = 8'h00;
	localparam logic [7:0] CMD_READ_GO   = 8'h30;
	localparam logic [7:0] CMD_PROG      = 8'h80;
	localparam logic [7:0] CMD_PROG_GO   = 8'h10;
	localparam logic [7:0] CMD_ERASE     = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
	localparam logic [7:0] CMD_STATUS    = 8'h70;
	localparam logic [7:0] CMD_RESET     = 8'hFF;
	localparam logic [7:0] CMD_UNLOCK_LO = 8'h23;
	localparam logic [7:0] CMD_UNLOCK_HI = 8'h24;

	// Data values
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] MARK_BAD    = 8'h00;

	// Array geometry and address layout
	localparam int         COL_W       = 13;
	localparam int         PAGE_W      = 6;
	localparam int         BLK_W       = 11;
	localparam int         PAGE_LSB    = 16;
	localparam int         BLK_LSB     = 22;
	localparam logic [2:0] ADDR_CYCLES = 3'h5;
	localparam logic [2:0] ROW_START   = 3'h2;
	localparam logic [BLK_W-1:0]  GOOD_BLOCKS = 11'h008;
	localparam logic [COL_W-1:0]  SPARE_COL   = 13'h1000;
	localparam logic [PAGE_W-1:0] LAST_PAGE   = 6'h3F;

	// Status register bit positions
	localparam int ST_FAIL  = 0;
	localparam int ST_ARDY  = 5;
	localparam int ST_RDY   = 6;
	localparam int ST_WPN   = 7;

	// Busy times in their own units, and cycle counts
	localparam int T_READ_US  = 55;
	localparam int T_PROG_US  = 350;
	localparam int T_ERASE_MS = 4;
	localparam int T_RESET_US = 5;
	localparam int T_POR_MS   = 3;
	localparam int READ_CYC   = T_READ_US * CLK_MHZ;
	localparam int PROG_CYC   = T_PROG_US * CLK_MHZ;
	localparam int ERASE_CYC  = T_ERASE_MS * 1000 * CLK_MHZ;
	localparam int RESET_CYC  = T_RESET_US * CLK_MHZ;
	localparam int POR_CYC    = T_POR_MS * 1000 * CLK_MHZ;
	localparam int BUSY_W     = 20;

	typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_DATA_IN, PH_BUSY, PH_DATA_OUT} phase_t;
endpackage

// ==== core/pin_sync.sv ====
// Purpose: Two-stage synchroniser for asynchronous pin inputs.
// Assumes: Each bit is an independent level.
// Notes:   No reset; the chain settles within two clocks of power-up.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock
	input  wire logic             mclk,
	// Pins in, synchronised out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	////////////////////////////////////////////////////////////////
	// First stage feeds only the second one
	always_ff @(posedge mclk) begin
		stage1   <= async_in;
		sync_out <= stage1;
	end
endmodule

// ==== core/nand_init_and_bad_block_handling.sv ====
// Purpose: Device-side command sequencer with block lock and bad-block marking.
// Assumes: Host strobes are slow against mclk (several clocks per WE/RE phase).
// Notes:   The array is modelled as erased; program data is counted, not kept.
`timescale 1ns/1ps
module nand_init_and_bad_block_handling
	import nand_seq_pkg::*;
#(
	parameter int               READ_BUSY_CYC  = READ_CYC,
	parameter int               PROG_BUSY_CYC  = PROG_CYC,
	parameter int               ERASE_BUSY_CYC = ERASE_CYC,
	parameter int               POR_BUSY_CYC   = POR_CYC,
	parameter logic [BLK_W-1:0] BAD_BLOCK      = 11'h100
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// Control pins
	input  wire logic       ce_n,
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       re_n,
	input  wire logic       wp_n,
	input  wire logic       lock_strap,
	// Data bus, split three ways
	input  wire logic [7:0] io_in,
	output logic      [7:0] io_out,
	output logic            io_oe,
	// Ready/busy
	output logic            rb_n
);
	logic [14:0]            sync_bus;
	logic                   s_ce_n, s_cle, s_ale, s_we_n, s_re_n, s_wp_n, s_strap;
	logic [7:0]             s_io;
	logic                   we_prev, re_prev;
	logic                   we_rise, re_rise, cmd_we, addr_we, data_we;
	phase_t                 phase;
	logic [7:0]             cmd;
	logic [2:0]             addr_idx;
	logic [39:0]            addr;
	logic [COL_W-1:0]       col;
	logic [BUSY_W-1:0]      busy_cnt;
	logic                   fail, init_done, show_status;
	logic                   lock_en, strap_taken, unlock_valid, marker_gone;
	logic [BLK_W-1:0]       lock_lo, lock_hi, blk;
	logic [PAGE_W-1:0]      page;
	logic                   blk_locked, marked, op_refused;
	logic [7:0]             data_byte, status_byte;

	////////////////////////////////////////////////////////////////
	// Pin synchronisation and strobe edges
	pin_sync #(.WIDTH(15)) u_sync (
		.mclk     (mclk),
		.async_in ({ce_n, cle, ale, we_n, re_n, wp_n, lock_strap, io_in}),
		.sync_out (sync_bus)
	);
	assign {s_ce_n, s_cle, s_ale, s_we_n, s_re_n, s_wp_n, s_strap, s_io} = sync_bus;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			we_prev <= 1'b1;
			re_prev <= 1'b1;
		end else begin
			we_prev <= s_we_n;
			re_prev <= s_re_n;
		end
	end

	// Strobes count only while selected; a deselected gap just freezes state
	assign we_rise = s_we_n && !we_prev && !s_ce_n;
	assign re_rise = s_re_n && !re_prev && !s_ce_n;
	assign cmd_we  = we_rise && s_cle && !s_ale;
	assign addr_we = we_rise && s_ale && !s_cle;
	assign data_we = we_rise && !s_ale && !s_cle;

	////////////////////////////////////////////////////////////////
	// Address decode, lock and marker lookup
	assign page = addr[PAGE_LSB +: PAGE_W];
	assign blk  = addr[BLK_LSB +: BLK_W];
	// With lock_en set, everything is locked until an unlock range has been written
	assign blk_locked = lock_en && !(unlock_valid && blk >= lock_lo && blk <= lock_hi);
	// Low blocks never carry a marker, whatever the parameter says
	assign marked = (blk == BAD_BLOCK) && (blk >= GOOD_BLOCKS) && !marker_gone;
	assign op_refused = blk_locked || !s_wp_n;
	// Spare byte 0 of first, second and last page holds the factory marker
	assign data_byte = (marked && col == SPARE_COL && (page == '0 || page == 6'h01 || page == LAST_PAGE))
		? MARK_BAD : ERASED_BYTE;
	assign status_byte = {s_wp_n, phase != PH_BUSY, phase != PH_BUSY, 4'h0, fail};

	////////////////////////////////////////////////////////////////
	// Volatile lock strap, caught once after reset release
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			lock_en     <= 1'b0;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			lock_en     <= s_strap;
			strap_taken <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Command, address and busy sequencing
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			phase        <= PH_BUSY;
			busy_cnt     <= BUSY_W'(POR_BUSY_CYC);
			cmd          <= CMD_RESET;
			addr_idx     <= 3'h0;
			addr         <= '0;
			col          <= '0;
			fail         <= 1'b0;
			init_done    <= 1'b0;
			show_status  <= 1'b0;
			unlock_valid <= 1'b0;
			lock_lo      <= '0;
			lock_hi      <= '0;
			marker_gone  <= 1'b0;
		end else if (cmd_we && s_io == CMD_RESET) begin
			// Reset is accepted even while busy and aborts the operation
			phase       <= PH_BUSY;
			busy_cnt    <= BUSY_W'(RESET_CYC);
			cmd         <= CMD_RESET;
			init_done   <= 1'b1;
			show_status <= 1'b0;
			fail        <= 1'b0;
		end else if (phase == PH_BUSY) begin
			if (cmd_we && s_io == CMD_STATUS && init_done)
				show_status <= 1'b1;
			if (busy_cnt <= BUSY_W'(1)) begin
				phase <= (cmd == CMD_READ) ? PH_DATA_OUT : PH_IDLE;
				col   <= addr[COL_W-1:0];
			end else begin
				busy_cnt <= busy_cnt - 1'b1;
			end
		end else if (cmd_we && init_done) begin
			unique case (s_io)
				CMD_STATUS: show_status <= 1'b1;
				CMD_READ: begin
					show_status <= 1'b0;
					// 00h after a status poll in the data-out phase only returns the bus to data
					if (!(phase == PH_DATA_OUT && show_status)) begin
						phase    <= PH_ADDR;
						cmd      <= CMD_READ;
						addr_idx <= 3'h0;
					end
				end
				CMD_PROG: begin
					show_status <= 1'b0;
					phase       <= PH_ADDR;
					cmd         <= CMD_PROG;
					addr_idx    <= 3'h0;
				end
				CMD_ERASE, CMD_UNLOCK_LO, CMD_UNLOCK_HI: begin
					show_status <= 1'b0;
					phase       <= PH_ADDR;
					cmd         <= s_io;
					addr_idx    <= ROW_START;
				end
				CMD_READ_GO: begin
					if (phase == PH_ADDR && cmd == CMD_READ) begin
						phase    <= PH_BUSY;
						busy_cnt <= BUSY_W'(READ_BUSY_CYC);
					end
				end
				CMD_PROG_GO: begin
					if (phase == PH_DATA_IN) begin
						phase    <= PH_BUSY;
						busy_cnt <= BUSY_W'(PROG_BUSY_CYC);
						fail     <= op_refused;
					end
				end
				CMD_ERASE_GO: begin
					if (phase == PH_ADDR && cmd == CMD_ERASE) begin
						phase    <= PH_BUSY;
						busy_cnt <= BUSY_W'(ERASE_BUSY_CYC);
						fail     <= op_refused;
						// An erase wipes the factory marker along with the data
						if (!op_refused && blk == BAD_BLOCK)
							marker_gone <= 1'b1;
					end
				end
				default: ;
			endcase
		end else if (addr_we && phase == PH_ADDR) begin
			addr[addr_idx*8 +: 8] <= s_io;
			addr_idx              <= addr_idx + 1'b1;
			if (addr_idx == ADDR_CYCLES - 1'b1) begin
				if (cmd == CMD_PROG) begin
					phase <= PH_DATA_IN;
					col   <= addr[COL_W-1:0];
				end else if (cmd == CMD_UNLOCK_LO) begin
					// Last row byte is still on the bus, so its low bit comes from s_io
					lock_lo <= {s_io[0], addr[31:BLK_LSB]};
					phase   <= PH_IDLE;
				end else if (cmd == CMD_UNLOCK_HI) begin
					lock_hi      <= {s_io[0], addr[31:BLK_LSB]};
					unlock_valid <= 1'b1;
					phase        <= PH_IDLE;
				end
			end
		end else if (data_we && phase == PH_DATA_IN) begin
			// Load bytes are only counted; the position survives CE gaps
			col <= col + 1'b1;
		end else if (re_rise && phase == PH_DATA_OUT && !show_status) begin
			col <= col + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Registered pin drivers
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			io_out <= 8'h00;
			io_oe  <= 1'b0;
			rb_n   <= 1'b0;
		end else begin
			io_out <= show_status ? status_byte : data_byte;
			io_oe  <= !s_ce_n && !s_re_n && (show_status || phase == PH_DATA_OUT);
			rb_n   <= (phase != PH_BUSY);
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	chk_init_first: assert property (
		(cmd_we && !init_done && s_io != CMD_RESET) |=> !init_done && $stable(phase))
		else $error("command accepted before first reset");
	chk_status_return: assert property (
		(cmd_we && init_done && s_io == CMD_READ && phase == PH_DATA_OUT && show_status)
		|=> !show_status && phase == PH_DATA_OUT && $stable(col))
		else $error("read command after status did not return to data");
	chk_locked_fail: assert property (
		(cmd_we && init_done && s_io == CMD_PROG_GO && phase == PH_DATA_IN && blk_locked)
		|=> fail && phase == PH_BUSY ##1 !rb_n)
		else $error("program to locked block not failed");
	chk_ce_gap_hold: assert property (
		(s_ce_n && phase == PH_DATA_OUT && !cmd_we) [*2] |-> $stable(col) && phase == PH_DATA_OUT)
		else $error("read position lost while deselected");
	chk_good_blocks: assert property (
		(phase == PH_DATA_OUT && !show_status && blk < GOOD_BLOCKS) |=> io_out == ERASED_BYTE)
		else $error("low block shows a bad marker");
	chk_erased_read: assert property (
		(phase == PH_DATA_OUT && !show_status && !marked) |=> io_out == ERASED_BYTE)
		else $error("valid block did not read erased");
endmodule

// ==== verif/nand_host_model.sv ====
// Purpose: Host controller model driving the NAND control pins and bus.
// Assumes: Strobe phases of 5 mclk (read-low phase 6), above the 4-clock minimum.
// Notes:   A released bus shows the inverse of the last byte.
`timescale 1ns/1ps
module nand_host_model (
	// Clock
	input  wire logic       mclk,
	// Pins toward the device
	output logic            ce_n,
	output logic            cle,
	output logic            ale,
	output logic            we_n,
	output logic            re_n,
	output logic      [7:0] io_in,
	// Pins from the device
	input  wire logic [7:0] io_out
);
	// Idle pins at time zero
	initial begin
		ce_n = 1'b1;
		cle = 1'b0;
		ale = 1'b0;
		we_n = 1'b1;
		re_n = 1'b1;
		io_in = 8'hA5;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// One latch cycle; the level stands well past the synchroniser delay
	task automatic wr(input logic c, input logic a, input logic [7:0] d);
		@(posedge mclk);
		ce_n <= 1'b0;
		cle <= c;
		ale <= a;
		io_in <= d;
		we_n <= 1'b0;
		hold(5);
		we_n <= 1'b1;
		hold(5);
		cle <= 1'b0;
		ale <= 1'b0;
		io_in <= ~d;
	endtask
	// Byte is taken while read strobe is still low
	task automatic rd(output logic [7:0] d);
		ce_n <= 1'b0;
		re_n <= 1'b0;
		hold(6);
		d = io_out;
		re_n <= 1'b1;
		hold(5);
	endtask
	// Chip select dropped between sequential bytes
	task automatic cs_gap();
		ce_n <= 1'b1;
		hold(8);
		ce_n <= 1'b0;
		hold(2);
	endtask
endmodule

// ==== verif/nand_init_and_bad_block_handling_test.sv ====
// Purpose: Self-checking bench for the NAND device-side sequencer.
// Assumes: Read, program, erase and power-up busy counts shortened to 20 cycles.
// Notes:   Expected bytes come from a small array model in the bench.
`timescale 1ns/1ps
module nand_init_and_bad_block_handling_test import nand_seq_pkg::*;;
	logic             mclk, rstn, wp_n, lock_strap, ce_n, cle, ale, we_n, re_n, io_oe, rb_n;
	logic       [7:0] io_in, io_out, got;
	logic      [31:0] lfsr;
	logic [BLK_W-1:0] blk;
	int               errors, n_tests, cyc, i, j, oe_hits;
	bit               saw, bad_erased;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
	nand_init_and_bad_block_handling #(.READ_BUSY_CYC(20), .PROG_BUSY_CYC(20), .ERASE_BUSY_CYC(20),
		.POR_BUSY_CYC(20)) i_nand_init_and_bad_block_handling (.mclk(mclk), .rstn(rstn), .ce_n(ce_n),
		.cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .lock_strap(lock_strap),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe), .rb_n(rb_n));
	nand_host_model i_nand_host_model (.mclk(mclk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.re_n(re_n), .io_in(io_in), .io_out(io_out));
	////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (io_oe === 1'b1)
			oe_hits++;
		if (cyc == 30000) begin
			errors++;
			final_report();
		end
	end
	function automatic logic [31:0] step(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Array model: erased, except the factory marker of the one bad block
	function automatic logic [7:0] exp_byte(input int b, input int p, input int c);
		if (c == SPARE_COL && b == 11'h100 && !bad_erased && (p < 2 || p == LAST_PAGE))
			return MARK_BAD;
		return ERASED_BYTE;
	endfunction
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Waits out a busy period; no busy seen within 40 cycles means refused
	task automatic busy();
		saw = 0;
		for (int k = 0; k < 40 && !saw; k++) begin
			@(posedge mclk);
			saw = (rb_n === 1'b0);
		end
		// Reset command busy alone runs 500 cycles
		for (int k = 0; k < 1000 && rb_n !== 1'b1; k++)
			@(posedge mclk);
		`CHK(rb_n, 1'b1)
	endtask
	task automatic cmd(input logic [7:0] c);
		i_nand_host_model.wr(1'b1, 1'b0, c);
	endtask
	task automatic addr(input int n, input logic [12:0] c, input int b, input int p);
		logic [23:0] row;
		row = 24'(b) * 64 + 24'(p);
		if (n == 5) begin
			i_nand_host_model.wr(1'b0, 1'b1, c[7:0]);
			i_nand_host_model.wr(1'b0, 1'b1, {3'h0, c[12:8]});
		end
		for (int k = 0; k < 3; k++)
			i_nand_host_model.wr(1'b0, 1'b1, row[8*k +: 8]);
	endtask
	task automatic rd_at(input int b, input int p, input logic [12:0] c);
		int oe0;
		cmd(CMD_READ);
		addr(5, c, b, p);
		cmd(CMD_READ_GO);
		busy();
		oe0 = oe_hits;
		i_nand_host_model.rd(got);
		`CHK(got, exp_byte(b, p, c))
		`CHK((oe_hits - oe0) > 2, 1'b1)
		`CHK(io_oe, 1'b0)
	endtask
	task automatic status(input logic fail);
		cmd(CMD_STATUS);
		i_nand_host_model.rd(got);
		`CHK(got, {wp_n, 2'b11, 4'h0, fail})
	endtask
	task automatic erase(input int b);
		cmd(CMD_ERASE);
		addr(3, 13'h0, b, 0);
		cmd(CMD_ERASE_GO);
		busy();
	endtask
	task automatic prog(input int b);
		cmd(CMD_PROG);
		addr(5, 13'h0, b, 2);
		for (int k = 0; k < 4; k++)
			i_nand_host_model.wr(1'b0, 1'b0, lfsr[7:0] ^ 8'(k));
		cmd(CMD_PROG_GO);
		busy();
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rstn = 1'b0;
		wp_n = 1'b1;
		lock_strap = 1'b1;
		lfsr = 32'h0807A300;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		busy();
		erase(5);
		`CHK(saw, 1'b0)
		cmd(CMD_RESET);
		busy();
		`CHK(saw, 1'b1)
		$display("test power-up reset done");
		cmd(CMD_READ);
		addr(5, SPARE_COL, 11'h100, 0);
		cmd(CMD_READ_GO);
		busy();
		status(1'b0);
		cmd(CMD_READ);
		i_nand_host_model.rd(got);
		`CHK(got, MARK_BAD)
		$display("test polled read done");
		for (i = 0; i < 3; i++)
			for (j = 0; j < 3; j++)
				rd_at(i == 0 ? 3 : 11'h100 + i - 1, j == 2 ? LAST_PAGE : j, SPARE_COL);
		$display("test marker scan done");
		rd_at(11'h100, 1, 13'h0FFF);
		i_nand_host_model.cs_gap();
		i_nand_host_model.rd(got);
		`CHK(got, MARK_BAD)
		$display("test select gap done");
		for (i = 0; i < 6; i++) begin
			lfsr = step(lfsr);
			blk = lfsr[31:21];
			rd_at(i < 2 ? 11'h100 : blk, lfsr[0] ? LAST_PAGE : lfsr[20:15], i < 2 ? SPARE_COL : lfsr[12:0] % 4352);
		end
		status(1'b0);
		$display("test random reads done");
		erase(5);
		status(1'b1);
		cmd(CMD_UNLOCK_LO);
		addr(3, 13'h0, 4, 0);
		cmd(CMD_UNLOCK_HI);
		addr(3, 13'h0, 11'h100, 0);
		erase(5);
		status(1'b0);
		prog(11'h101);
		status(1'b1);
		wp_n <= 1'b0;
		prog(5);
		status(1'b1);
		wp_n <= 1'b1;
		// Write protect off again: a program to block 6, inside the unlock range, passes
		prog(6);
		status(1'b0);
		$display("test lock and protect done");
		erase(11'h100);
		status(1'b0);
		bad_erased = 1;
		rd_at(11'h100, 0, SPARE_COL);
		$display("test marker erase done");
		// Second power-up with the lock strap off: nothing is locked
		lock_strap <= 1'b0;
		rstn <= 1'b0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		busy();
		cmd(CMD_RESET);
		busy();
		erase(11'h102);
		status(1'b0);
		$display("test lock strap off done");
		final_report();
	end
endmodule
